// ---- rtl/cmp_pkg.sv ----
// Constants shared by the configuration message port
package cmp_pkg;
  // ****************************************
  // Message tokens
  // ****************************************
  localparam logic [7:0]  CMP_TOK_WRITE   = 8'hc0;
  localparam logic [7:0]  CMP_TOK_READ    = 8'hc1;
  localparam logic [7:0]  CMP_TOK_END     = 8'h01;
  localparam logic [7:0]  CMP_TOK_ACK     = 8'h03;
  localparam logic [7:0]  CMP_TOK_NACK    = 8'h04;
  // ****************************************
  // Field widths and counts
  // ****************************************
  localparam int          CMP_RID_W       = 24;
  localparam int          CMP_REG_W       = 16;
  localparam int          CMP_DATA_W      = 32;
  localparam logic [1:0]  CMP_RID_LAST    = 2'h2;
  localparam logic [1:0]  CMP_REG_LAST    = 2'h1;
  localparam logic [1:0]  CMP_DATA_LAST   = 2'h3;
  localparam logic [7:0]  CMP_NO_REPLY    = 8'hff;
  // ****************************************
  // Destination low patterns
  // ****************************************
  localparam logic [15:0] CMP_DEST_TILE   = 16'hc20c;
  localparam logic [15:0] CMP_DEST_NODE   = 16'hc30c;
  // ****************************************
  // Processor-status resource identifiers
  // ****************************************
  localparam int          CMP_PS_NUM_W    = 24;
  localparam int          CMP_PS_SHIFT    = 8;
  localparam logic [7:0]  CMP_PS_TYPE     = 8'h0b;
endpackage

// ---- rtl/cmp_ps_if.sv ----
// Carrier between the message port and the status identifier unit
`timescale 1ns/10ps
`default_nettype none
interface cmp_ps_if;
  import cmp_pkg::*;
  logic                    req;
  logic                    wr;
  logic [CMP_PS_NUM_W-1:0] num;
  logic [CMP_DATA_W-1:0]   wdata;
  logic                    res_valid;
  logic                    res_wr;
  logic [CMP_DATA_W-1:0]   res_id;
  logic [CMP_DATA_W-1:0]   res_wdata;
  modport top  (output req, wr, num, wdata, input res_valid, res_wr, res_id, res_wdata);
  modport unit (input req, wr, num, wdata, output res_valid, res_wr, res_id, res_wdata);
endinterface
`default_nettype wire

// ---- rtl/cmp_ps_xlate.sv ----
// Processor-status register number to resource identifier
`timescale 1ns/10ps
`default_nettype none
module cmp_ps_xlate
  import cmp_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Status access
  cmp_ps_if.unit    ps
);
  logic                  valid_reg, valid_next;
  logic                  wr_reg,    wr_next;
  logic [CMP_DATA_W-1:0] id_reg,    id_next;
  logic [CMP_DATA_W-1:0] wd_reg,    wd_next;

  always_comb begin
    valid_next = ps.req;
    wr_next    = wr_reg;
    id_next    = id_reg;
    wd_next    = wd_reg;
    if (ps.req) begin
      wr_next = ps.wr;
      wd_next = ps.wdata;
      id_next = {ps.num[CMP_DATA_W-CMP_PS_SHIFT-1:0], {CMP_PS_SHIFT{1'b0}}} |
                {{(CMP_DATA_W-8){1'b0}}, CMP_PS_TYPE};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      valid_reg <= 1'b0;
      wr_reg    <= 1'b0;
      id_reg    <= '0;
      wd_reg    <= '0;
    end else begin
      valid_reg <= valid_next;
      wr_reg    <= wr_next;
      id_reg    <= id_next;
      wd_reg    <= wd_next;
    end
  end

  assign ps.res_valid = valid_reg;
  assign ps.res_wr    = wr_reg;
  assign ps.res_id    = id_reg;
  assign ps.res_wdata = wd_reg;
endmodule // cmp_ps_xlate
`default_nettype wire

// ---- rtl/cmp_port.sv ----
// Configuration register message port: decodes request tokens, replies
// ****************************************
// Functional notes
// - Write reply: tokens 3 then 1 on success, 4 then 1 on failure.
// - Read reply: token 3, 32-bit value, token 1; failure is tokens 4, 1.
// - Reply id is upper 24 bits of reply channel-end; replies go there.
// - Write with reply id low byte all ones: write done, no reply.
// - All multi-byte fields travel most significant byte first.
// - Node registers use identical request and reply formats as tile registers.
// - Local processor reads or writes status registers directly, no message.
// - Status resource id is register number shifted left 8, ORed 0x0B.
// ****************************************
`timescale 1ns/10ps
`default_nettype none
module cmp_port
  import cmp_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // Incoming token stream
  input  wire logic                    in_valid,
  input  wire logic                    in_ctrl,
  input  wire logic [7:0]              in_byte,
  input  wire logic [15:0]             in_dest_low,
  output logic                         in_ready,
  // Outgoing reply stream
  output logic                         out_valid,
  output logic                         out_ctrl,
  output logic [7:0]                   out_byte,
  output logic [CMP_RID_W-1:0]         out_dest,
  input  wire logic                    out_ready,
  // Register bank access
  output logic                         reg_req,
  output logic                         reg_write,
  output logic                         reg_node,
  output logic [CMP_REG_W-1:0]         reg_addr,
  output logic [CMP_DATA_W-1:0]        reg_wdata,
  input  wire logic                    reg_ack,
  input  wire logic                    reg_err,
  input  wire logic [CMP_DATA_W-1:0]   reg_rdata,
  // Local processor-status access
  input  wire logic                    ps_req,
  input  wire logic                    ps_wr,
  input  wire logic [CMP_PS_NUM_W-1:0] ps_num,
  input  wire logic [CMP_DATA_W-1:0]   ps_wdata,
  output logic                         ps_res_valid,
  output logic                         ps_res_wr,
  output logic [CMP_DATA_W-1:0]        ps_res_id,
  output logic [CMP_DATA_W-1:0]        ps_res_wdata
);
  // ****************************************
  // Status identifier unit
  // ****************************************
  cmp_ps_if ps_bus ();
  assign ps_bus.req   = ps_req;
  assign ps_bus.wr    = ps_wr;
  assign ps_bus.num   = ps_num;
  assign ps_bus.wdata = ps_wdata;
  assign ps_res_valid = ps_bus.res_valid;
  assign ps_res_wr    = ps_bus.res_wr;
  assign ps_res_id    = ps_bus.res_id;
  assign ps_res_wdata = ps_bus.res_wdata;

  cmp_ps_xlate u_ps_xlate (
    .clk     (clk),
    .reset_n (reset_n),
    .ps      (ps_bus)
  );

  // ****************************************
  // Message state machine
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_RID, ST_REG, ST_DATA, ST_END, ST_ACC, ST_DRAIN, ST_TX_HDR, ST_TX_DATA, ST_TX_END
  } cmp_state_t;

  cmp_state_t            state_reg,   state_next;
  logic [1:0]            cnt_reg,     cnt_next;
  logic                  wr_reg,      wr_next;
  logic                  node_reg,    node_next;
  logic                  ok_reg,      ok_next;
  logic                  fail_reg,    fail_next;
  logic [CMP_RID_W-1:0]  rid_reg,     rid_next;
  logic [CMP_REG_W-1:0]  addr_reg,    addr_next;
  logic [CMP_DATA_W-1:0] data_reg,    data_next;
  logic                  req_reg,     req_next;
  logic                  inrdy_reg,   inrdy_next;
  logic                  ovalid_reg,  ovalid_next;
  logic                  octrl_reg,   octrl_next;
  logic [7:0]            obyte_reg,   obyte_next;
  logic                  rx;
  logic                  load;
  logic                  is_end;

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    wr_next     = wr_reg;
    node_next   = node_reg;
    ok_next     = ok_reg;
    fail_next   = fail_reg;
    rid_next    = rid_reg;
    addr_next   = addr_reg;
    data_next   = data_reg;
    req_next    = 1'b0;
    octrl_next  = octrl_reg;
    obyte_next  = obyte_reg;
    ovalid_next = ovalid_reg && !out_ready;
    rx          = in_valid && inrdy_reg;
    load        = !ovalid_reg || out_ready;
    is_end      = in_ctrl && (in_byte == CMP_TOK_END);
    // Stray control token inside a field: abort framing, fail once id is known
    if (rx && in_ctrl && (state_reg == ST_RID || state_reg == ST_REG || state_reg == ST_DATA)) begin
      ok_next    = 1'b0;
      cnt_next   = '0;
      fail_next  = (state_reg != ST_RID);
      state_next = is_end ? ((state_reg == ST_RID) ? ST_IDLE : ST_TX_HDR) : ST_DRAIN;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (rx) begin
            if (in_ctrl && (in_byte == CMP_TOK_WRITE || in_byte == CMP_TOK_READ)) begin
              wr_next    = (in_byte == CMP_TOK_WRITE);
              node_next  = (in_dest_low == CMP_DEST_NODE);
              fail_next  = 1'b0;
              cnt_next   = '0;
              state_next = ST_RID;
            end else if (!is_end) begin
              fail_next  = 1'b0;
              state_next = ST_DRAIN;
            end
          end
        end
        ST_RID: begin
          if (rx) begin
            rid_next = {rid_reg[CMP_RID_W-9:0], in_byte};
            cnt_next = cnt_reg + 2'h1;
            if (cnt_reg == CMP_RID_LAST) begin
              cnt_next   = '0;
              state_next = ST_REG;
            end
          end
        end
        ST_REG: begin
          if (rx) begin
            addr_next = {addr_reg[CMP_REG_W-9:0], in_byte};
            cnt_next  = cnt_reg + 2'h1;
            if (cnt_reg == CMP_REG_LAST) begin
              cnt_next   = '0;
              state_next = wr_reg ? ST_DATA : ST_END;
            end
          end
        end
        ST_DATA: begin
          if (rx) begin
            data_next = {data_reg[CMP_DATA_W-9:0], in_byte};
            cnt_next  = cnt_reg + 2'h1;
            if (cnt_reg == CMP_DATA_LAST) begin
              cnt_next   = '0;
              state_next = ST_END;
            end
          end
        end
        ST_END: begin
          if (rx) begin
            if (is_end) begin
              req_next   = 1'b1;
              state_next = ST_ACC;
            end else begin
              // Overlong message: swallow the rest, then answer with failure
              ok_next    = 1'b0;
              fail_next  = 1'b1;
              state_next = is_end ? ST_TX_HDR : ST_DRAIN;
            end
          end
        end
        ST_ACC: begin
          if (reg_ack) begin
            ok_next   = !reg_err;
            data_next = reg_rdata;
            if (wr_reg && rid_reg[7:0] == CMP_NO_REPLY) begin
              state_next = ST_IDLE;
            end else begin
              state_next = ST_TX_HDR;
            end
          end
        end
        ST_DRAIN: begin
          if (rx && is_end) begin
            state_next = fail_reg ? ST_TX_HDR : ST_IDLE;
          end
        end
        ST_TX_HDR: begin
          if (load) begin
            ovalid_next = 1'b1;
            octrl_next  = 1'b1;
            obyte_next  = ok_reg ? CMP_TOK_ACK : CMP_TOK_NACK;
            cnt_next    = '0;
            state_next  = (ok_reg && !wr_reg) ? ST_TX_DATA : ST_TX_END;
          end
        end
        ST_TX_DATA: begin
          if (load) begin
            ovalid_next = 1'b1;
            octrl_next  = 1'b0;
            obyte_next  = data_reg[CMP_DATA_W-1 -: 8];
            data_next   = {data_reg[CMP_DATA_W-9:0], 8'h00};
            cnt_next    = cnt_reg + 2'h1;
            if (cnt_reg == CMP_DATA_LAST) begin
              state_next = ST_TX_END;
            end
          end
        end
        ST_TX_END: begin
          if (load) begin
            ovalid_next = 1'b1;
            octrl_next  = 1'b1;
            obyte_next  = CMP_TOK_END;
            state_next  = ST_IDLE;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
    // No new id may overwrite the reply address while a reply token waits
    inrdy_next = !ovalid_next && ((state_next == ST_IDLE) || (state_next == ST_RID) || (state_next == ST_REG) ||
                 (state_next == ST_DATA) || (state_next == ST_END) || (state_next == ST_DRAIN));
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= '0;
      wr_reg     <= 1'b0;
      node_reg   <= 1'b0;
      ok_reg     <= 1'b0;
      fail_reg   <= 1'b0;
      rid_reg    <= '0;
      addr_reg   <= '0;
      data_reg   <= '0;
      req_reg    <= 1'b0;
      inrdy_reg  <= 1'b0;
      ovalid_reg <= 1'b0;
      octrl_reg  <= 1'b0;
      obyte_reg  <= '0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      wr_reg     <= wr_next;
      node_reg   <= node_next;
      ok_reg     <= ok_next;
      fail_reg   <= fail_next;
      rid_reg    <= rid_next;
      addr_reg   <= addr_next;
      data_reg   <= data_next;
      req_reg    <= req_next;
      inrdy_reg  <= inrdy_next;
      ovalid_reg <= ovalid_next;
      octrl_reg  <= octrl_next;
      obyte_reg  <= obyte_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign in_ready  = inrdy_reg;
  assign out_valid = ovalid_reg;
  assign out_ctrl  = octrl_reg;
  assign out_byte  = obyte_reg;
  assign out_dest  = rid_reg;
  assign reg_req   = req_reg;
  assign reg_write = wr_reg;
  assign reg_node  = node_reg;
  assign reg_addr  = addr_reg;
  assign reg_wdata = data_reg;
endmodule // cmp_port
`default_nettype wire

// ---- verif/cmp_sva.sv ----
// Assertion checker for the configuration message port
`timescale 1ns/10ps
`default_nettype none
module cmp_sva
  import cmp_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Streams
  input wire logic        in_ready,
  input wire logic        out_valid,
  input wire logic        out_ctrl,
  input wire logic [7:0]  out_byte,
  input wire logic        out_ready,
  input wire logic [23:0] out_dest,
  // Register bank
  input wire logic        reg_req,
  input wire logic        reg_write,
  input wire logic        reg_ack,
  input wire logic        reg_err,
  // Status path
  input wire logic        ps_req,
  input wire logic        ps_wr,
  input wire logic [23:0] ps_num,
  input wire logic [31:0] ps_wdata,
  input wire logic        ps_res_valid,
  input wire logic        ps_res_wr,
  input wire logic [31:0] ps_res_id,
  input wire logic [31:0] ps_res_wdata
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_ps_pulse; ps_req |=> ps_res_valid; endproperty
  a_ps_pulse: assert property (p_ps_pulse) else $error("status result missing");
  property p_ps_once; !ps_req |=> !ps_res_valid; endproperty
  a_ps_once: assert property (p_ps_once) else $error("stray status result");
  property p_ps_id; ps_req |=> ps_res_id == {$past(ps_num), CMP_PS_TYPE}; endproperty
  a_ps_id: assert property (p_ps_id) else $error("status id wrong");
  property p_ps_fwd; ps_req |=> ps_res_wr == $past(ps_wr) && ps_res_wdata == $past(ps_wdata); endproperty
  a_ps_fwd: assert property (p_ps_fwd) else $error("status write fields wrong");
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_byte) && $stable(out_ctrl); endproperty
  a_hold: assert property (p_hold) else $error("reply token dropped");
  property p_head; $rose(out_valid) |-> out_ctrl && (out_byte == CMP_TOK_ACK || out_byte == CMP_TOK_NACK); endproperty
  a_head: assert property (p_head) else $error("reply header wrong");
  property p_nack_end;
    out_valid && out_ready && out_ctrl && out_byte == CMP_TOK_NACK |=> out_valid && out_ctrl && out_byte == CMP_TOK_END;
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("failure not ended");
  // A failed silent write stays silent, so it is left out here
  property p_fail;
    reg_ack && reg_err && !(reg_write && out_dest[7:0] == CMP_NO_REPLY) |->
      ##[1:3] out_valid && out_ctrl && out_byte == CMP_TOK_NACK;
  endproperty
  a_fail: assert property (p_fail) else $error("failure reply missing");
  property p_dest; out_valid && !out_ready |=> $stable(out_dest); endproperty
  a_dest: assert property (p_dest) else $error("reply address moved");
  property p_rd_ok; reg_ack && !reg_err && !reg_write |-> ##[1:3] out_valid && out_byte == CMP_TOK_ACK; endproperty
  a_rd_ok: assert property (p_rd_ok) else $error("read success reply missing");
  property p_busy; reg_req |-> !in_ready; endproperty
  a_busy: assert property (p_busy) else $error("tokens taken during access");
  c_fail: cover property (reg_ack && reg_err);
  c_ack: cover property (out_valid && out_ready && out_byte == CMP_TOK_ACK);
  c_ps: cover property (ps_req ##1 ps_req);
endmodule // cmp_sva
bind cmp_port cmp_sva u_sva (.clk, .reset_n, .in_ready, .out_valid, .out_ctrl, .out_byte, .out_ready, .out_dest, .reg_req,
  .reg_write, .reg_ack, .reg_err, .ps_req, .ps_wr, .ps_num, .ps_wdata, .ps_res_valid, .ps_res_wr, .ps_res_id,
  .ps_res_wdata);
`default_nettype wire

// ---- verif/cmp_bank_model.sv ----
// Register bank model answering the port's accesses
`timescale 1ns/10ps
`default_nettype none
module cmp_bank_model
  import cmp_pkg::*;
(
  // Clock
  input wire logic         clk,
  // Access
  input wire logic         reg_req,
  input wire logic         reg_write,
  input wire logic         reg_node,
  input wire logic [15:0]  reg_addr,
  input wire logic [31:0]  reg_wdata,
  output logic             reg_ack,
  output logic             reg_err,
  output logic [31:0]      reg_rdata
);
  bit [31:0] mem [bit [16:0]];
  bit        ok;
  initial begin
    reg_ack = 1'b0;
    reg_err = 1'b0;
    reg_rdata = 32'h0;
    forever begin
      @(posedge clk);
      if (reg_req === 1'b1) begin
        ok = reg_addr < 16'h0010 && !(reg_write && reg_addr == 16'h0003);
        if (ok && reg_write) mem[{reg_node, reg_addr}] = reg_wdata;
        repeat ($urandom % 4) @(posedge clk);
        reg_ack <= 1'b1;
        reg_err <= !ok;
        reg_rdata <= mem[{reg_node, reg_addr}];
        @(posedge clk);
        reg_ack <= 1'b0;
        reg_err <= 1'b0;
        // Stale data must not look valid
        reg_rdata <= ~reg_rdata;
      end
    end
  end
endmodule // cmp_bank_model
`default_nettype wire

// ---- verif/config_register_message_port_test.sv ----
// Self-checking testbench for the configuration message port
`timescale 1ns/10ps
`default_nettype none
module config_register_message_port_test;
  import cmp_pkg::*;
  logic        clk = 1'b0, reset_n = 1'b0, in_valid = 1'b0, in_ctrl = 1'b0, out_ready = 1'b0;
  logic        ps_req = 1'b0, ps_wr = 1'b0;
  logic [7:0]  in_byte = 8'h00, out_byte;
  logic [15:0] in_dest_low = 16'h0000, reg_addr;
  logic [23:0] ps_num = 24'h0, out_dest;
  logic [31:0] ps_wdata = 32'h0, reg_wdata, reg_rdata, ps_res_id, ps_res_wdata;
  logic        in_ready, out_valid, out_ctrl, reg_req, reg_write, reg_node, reg_ack, reg_err, ps_res_valid, ps_res_wr;
  int          err_count = 0, check_count = 0;
  bit [31:0]   mem [bit [16:0]];
  logic [32:0] exp_q [$], got_q [$];
  always #4 clk = ~clk;
  cmp_port u_dut (.clk, .reset_n, .in_valid, .in_ctrl, .in_byte, .in_dest_low, .in_ready, .out_valid, .out_ctrl,
    .out_byte, .out_dest, .out_ready, .reg_req, .reg_write, .reg_node, .reg_addr, .reg_wdata, .reg_ack, .reg_err,
    .reg_rdata, .ps_req, .ps_wr, .ps_num, .ps_wdata, .ps_res_valid, .ps_res_wr, .ps_res_id, .ps_res_wdata);
  cmp_bank_model u_bank (.clk, .reg_req, .reg_write, .reg_node, .reg_addr, .reg_wdata, .reg_ack, .reg_err, .reg_rdata);
  // ****************************************
  // Reply sink with random stalls
  // ****************************************
  always @(posedge clk) begin
    out_ready <= ($urandom % 4) != 0;
    if (out_valid === 1'b1 && out_ready === 1'b1) got_q.push_back({out_dest, out_ctrl, out_byte});
  end
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] want);
    check_count++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic tok(input logic c, input logic [7:0] b);
    in_valid <= 1'b1;
    in_ctrl <= c;
    in_byte <= b;
    do @(posedge clk); while (in_ready !== 1'b1);
  endtask
  // Cut messages end inside the register number and always earn a failure reply
  task automatic msg(input bit wr, input bit node, input logic [23:0] rid, input logic [15:0] ra, input logic [31:0] d,
                     input bit cut);
    bit ok;
    int n;
    ok = !cut && ra < 16'h0010 && !(wr && ra == 16'h0003);
    in_dest_low <= node ? CMP_DEST_NODE : CMP_DEST_TILE;
    tok(1'b1, wr ? CMP_TOK_WRITE : CMP_TOK_READ);
    for (int i = 2; i >= 0; i--) tok(1'b0, rid[i*8 +: 8]);
    for (int i = 1; i >= int'(cut); i--) tok(1'b0, ra[i*8 +: 8]);
    if (wr && !cut) for (int i = 3; i >= 0; i--) tok(1'b0, d[i*8 +: 8]);
    tok(1'b1, CMP_TOK_END);
    in_valid <= 1'b0;
    if (wr && ok) mem[{node, ra}] = d;
    if (cut || !(wr && rid[7:0] == CMP_NO_REPLY)) begin
      exp_q.push_back({rid, 1'b1, ok ? CMP_TOK_ACK : CMP_TOK_NACK});
      if (ok && !wr) for (int i = 3; i >= 0; i--) exp_q.push_back({rid, 1'b0, mem[{node, ra}][i*8 +: 8]});
      exp_q.push_back({rid, 1'b1, CMP_TOK_END});
    end
    n = 0;
    while (got_q.size() < exp_q.size() && n < 100) begin
      @(posedge clk);
      n++;
    end
    repeat (12) @(posedge clk);
    check("reply length", 33'(got_q.size()), 33'(exp_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0)
      check("reply token", got_q.pop_front(), exp_q.pop_front());
    got_q.delete();
    exp_q.delete();
  endtask
  // Hold keeps the request up a second cycle to exercise back-to-back accesses
  task automatic ps_check(input bit hold);
    logic [23:0] num;
    logic [31:0] wd;
    logic        wr;
    num = 24'($urandom);
    wd = $urandom;
    wr = 1'($urandom);
    ps_req <= 1'b1;
    ps_wr <= wr;
    ps_num <= num;
    ps_wdata <= wd;
    @(posedge clk);
    ps_req <= hold;
    #1;
    check("status valid", 33'(ps_res_valid), 33'h1);
    check("status id", 33'(ps_res_id), 33'((32'(num) << CMP_PS_SHIFT) | 32'h0000000b));
    check("status data", {ps_res_wr, ps_res_wdata}, {wr, wd});
    @(posedge clk);
    if (hold) begin
      ps_req <= 1'b0;
      #1;
      check("status repeat", 33'(ps_res_valid), 33'h1);
      check("status repeat id", 33'(ps_res_id), 33'((32'(num) << CMP_PS_SHIFT) | 32'h0000000b));
      @(posedge clk);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h3632));
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    msg(1'b1, 1'b0, 24'h010203, 16'h0005, 32'ha1b2c3d4, 1'b0);
    msg(1'b0, 1'b0, 24'h010203, 16'h0005, 32'h0, 1'b0);
    // Silent write on node bank, then read it back
    msg(1'b1, 1'b1, 24'h0a0bff, 16'h0005, 32'h11223344, 1'b0);
    msg(1'b0, 1'b1, 24'h0a0b0c, 16'h0005, 32'h0, 1'b0);
    msg(1'b1, 1'b0, 24'h0c0d0e, 16'h0003, 32'h5, 1'b0);
    msg(1'b0, 1'b1, 24'h0c0d0e, 16'h0100, 32'h0, 1'b0);
    // Malformed write: a reply comes back even with the silent id
    msg(1'b1, 1'b0, 24'h0d0eff, 16'h0005, 32'h0, 1'b1);
    $display("test directed done");
    for (int k = 0; k < 16; k++)
      msg(1'($urandom), 1'($urandom), 24'($urandom), 16'($urandom % 20), $urandom, 1'(($urandom % 8) == 0));
    $display("test random done");
    for (int k = 0; k < 8; k++) ps_check(k[0]);
    $display("test status done");
    print_verdict();
  end
endmodule // config_register_message_port_test
`default_nettype wire
